/* File: design/cfg_spi_device.sv */
// Local design decisions: the address map and the strobed register port.
`timescale 1ns/1ps
// Behaviour
// - Reset leaves port in three-wire mode
// - Reads work in three-wire and four-wire mode
// - Four-wire enable bit switches port mode
// - Four-wire readback on dedicated pin or lane0
// - Frame: select falls, instruction, data, rises
// - Sample on rising, change on falling
// - All fields travel MSB first
// - Direction bit then fifteen-bit address
// - Streaming reaches consecutive addresses until select rises
// - Non-streaming: one byte per instruction, repeatable
// - Commit each written byte immediately, or after its checksum byte with checksum on
// - With checksum on, write only if valid
// - Shared line turns round after instruction on three-wire reads
// - Port uses conversion lane0 only for four-wire readback
// - Instruction mode bit selects streaming or not
// - Address steps per direction bit, wraps 0x71
// - Loop count clears at frame end unless kept
// - Checksum x^8+x^2+x+1, seed 0xa5
module cfg_spi_device
  import cfg_spi_pkg::*;
(
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic CE_I,
  output logic FOUR_WIRE_O,
  cfg_spi_if.dev BUS
);

  typedef enum logic [1:0] {
    P_IDLE = 2'b00,
    P_INSTR = 2'b01,
    P_DATA = 2'b10,
    P_CRC = 2'b11
  } dev_phase_t;

  typedef struct packed {
    logic sclk_s1;
    logic sclk_s2;
    logic sclk_prev;
    logic sel_s1;
    logic sel_s2;
    logic sel_prev;
    logic din_s1;
    logic din_s2;
    dev_phase_t phase;
    logic [3:0] cnt;
    logic [15:0] sr;
    logic rd;
    logic [14:0] addr;
    logic [7:0] held;
    logic [7:0] tx;
    logic [7:0] crc;
    logic out_bit;
    logic sdio_oe_n;
    logic cdo_oe_n;
    logic lane0_oe_n;
    logic four_wire;
    reg_file_t mem;
  } dev_state_t;

  dev_state_t s_q, s_d;
  logic sclk_rise;
  logic sclk_fall;
  logic sel_fall;
  logic sel_rise;

  // Register byte seen by a read; unmapped addresses read zero
  function automatic logic [7:0] read_byte(input reg_file_t mem, input logic [14:0] addr);
    return (addr <= ADDR_LAST) ? mem[addr[6:0]] : 8'h00;
  endfunction

  // Streaming address step with wrap at both ends of the map
  function automatic logic [14:0] step_addr(input logic [14:0] addr, input logic up);
    if (up) begin
      return (addr >= ADDR_LAST) ? 15'h0000 : 15'(addr + 15'h0001);
    end
    return (addr == 15'h0000) ? ADDR_LAST : 15'(addr - 15'h0001);
  endfunction

  // Edges from the second synchroniser stage and its delayed copy
  assign sclk_rise = s_q.sclk_s2 && !s_q.sclk_prev;
  assign sclk_fall = !s_q.sclk_s2 && s_q.sclk_prev;
  assign sel_fall = !s_q.sel_s2 && s_q.sel_prev;
  assign sel_rise = s_q.sel_s2 && !s_q.sel_prev;

  // Next state: frame decoding, register file and readback driver
  always_comb begin
    logic [15:0] sr_new;
    logic [7:0] byte_in;
    logic advance;
    logic crc_on;
    logic stream;
    logic [14:0] next_addr;
    logic [7:0] next_byte;
    sr_new = {s_q.sr[14:0], s_q.din_s2};
    byte_in = sr_new[7:0];
    advance = 1'b0;
    crc_on = s_q.mem[ADDR_PORT_CFG_C[6:0]][BIT_CRC_EN];
    stream = !s_q.mem[ADDR_PORT_CFG_B[6:0]][BIT_INSTR_MODE];
    next_addr = step_addr(s_q.addr, s_q.mem[ADDR_PORT_CFG_A[6:0]][BIT_ADDR_DIR]);
    next_byte = read_byte(s_q.mem, next_addr);
    s_d = s_q;
    // Only the config pins are watched; conversion lanes are untouched here
    s_d.sclk_s1 = BUS.cfg_serial_clock;
    s_d.sclk_s2 = s_q.sclk_s1;
    s_d.sclk_prev = s_q.sclk_s2;
    s_d.sel_s1 = BUS.frame_sel_n;
    s_d.sel_s2 = s_q.sel_s1;
    s_d.sel_prev = s_q.sel_s2;
    s_d.din_s1 = BUS.cfg_data_bidir;
    s_d.din_s2 = s_q.din_s1;
    s_d.four_wire = s_q.mem[ADDR_PORT_CFG_A[6:0]][BIT_FOUR_WIRE];
    if (s_q.sel_s2) begin
      // Select high ends the frame; any partial byte is simply forgotten
      s_d.phase = P_IDLE;
      s_d.cnt = 4'h0;
      s_d.sdio_oe_n = 1'b1;
      s_d.cdo_oe_n = 1'b1;
      s_d.lane0_oe_n = 1'b1;
      if (sel_rise && !s_q.mem[ADDR_LOOP_CFG_B[6:0]][BIT_KEEP_LOOP]) begin
        s_d.mem[ADDR_LOOP_CFG_A[6:0]] = REG_RESET;
      end
    end else if (sel_fall) begin
      s_d.phase = P_INSTR;
      s_d.cnt = 4'h0;
    end else if (sclk_rise) begin
      // Input bits captured on rising edges, MSB first
      s_d.sr = sr_new;
      s_d.cnt = s_q.cnt + 4'h1;
      case (s_q.phase)
        P_INSTR: begin
          if (s_q.cnt == 4'(INSTR_BITS - 1)) begin
            s_d.rd = sr_new[15];
            s_d.addr = sr_new[14:0];
            s_d.cnt = 4'h0;
            s_d.phase = P_DATA;
            if (sr_new[15]) begin
              s_d.tx = read_byte(s_q.mem, sr_new[14:0]);
              s_d.crc = crc8_byte(CRC_INIT, read_byte(s_q.mem, sr_new[14:0]));
              // Turn round only after the last instruction rising edge
              s_d.sdio_oe_n = s_q.four_wire;
              s_d.cdo_oe_n = !(s_q.four_wire && !s_q.mem[ADDR_PORT_CFG_D[6:0]][BIT_LANE0]);
              s_d.lane0_oe_n = !(s_q.four_wire && s_q.mem[ADDR_PORT_CFG_D[6:0]][BIT_LANE0]);
            end
          end
        end
        P_DATA: begin
          if (s_q.cnt == 4'(BYTE_BITS - 1)) begin
            s_d.cnt = 4'h0;
            if (crc_on) begin
              s_d.held = byte_in;
              s_d.tx = s_q.crc;
              s_d.phase = P_CRC;
            end else begin
              if (!s_q.rd && s_q.addr <= ADDR_LAST) begin
                s_d.mem[s_q.addr[6:0]] = byte_in;
              end
              advance = 1'b1;
            end
          end
        end
        P_CRC: begin
          if (s_q.cnt == 4'(BYTE_BITS - 1)) begin
            s_d.cnt = 4'h0;
            // Bad checksum leaves the register as it was
            if (!s_q.rd && s_q.addr <= ADDR_LAST &&
                byte_in == crc8_byte(CRC_INIT, s_q.held)) begin
              s_d.mem[s_q.addr[6:0]] = s_q.held;
            end
            advance = 1'b1;
          end
        end
        default: begin
          s_d.cnt = 4'h0;
        end
      endcase
      if (advance) begin
        if (stream) begin
          // One instruction, then consecutive addresses until select rises
          s_d.addr = next_addr;
          s_d.phase = P_DATA;
          s_d.tx = next_byte;
          s_d.crc = crc8_byte(CRC_INIT, next_byte);
        end else begin
          // Single byte per instruction; a fresh instruction may follow
          s_d.phase = P_INSTR;
          s_d.sdio_oe_n = 1'b1;
          s_d.cdo_oe_n = 1'b1;
          s_d.lane0_oe_n = 1'b1;
        end
      end
    end else if (sclk_fall && s_q.rd && (s_q.phase == P_DATA || s_q.phase == P_CRC)) begin
      // Output changes on falling edges, MSB first
      s_d.out_bit = s_q.tx[7];
      s_d.tx = {s_q.tx[6:0], 1'b0};
    end
  end

  // State register; registers reset to their defaults, port in 3-wire mode
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      s_q <= '0;
      s_q.sclk_prev <= 1'b0;
      s_q.sel_s1 <= 1'b1;
      s_q.sel_s2 <= 1'b1;
      s_q.sel_prev <= 1'b1;
      s_q.sdio_oe_n <= 1'b1;
      s_q.cdo_oe_n <= 1'b1;
      s_q.lane0_oe_n <= 1'b1;
      s_q.mem <= {(MEM_TOP + 1){REG_RESET}};
    end else if (CE_I) begin
      s_q <= s_d;
    end
  end

  // All pin drivers come straight from state flops
  assign FOUR_WIRE_O = s_q.four_wire;
  assign BUS.dev_sdio_o = s_q.out_bit;
  assign BUS.dev_sdio_oe_n = s_q.sdio_oe_n;
  assign BUS.cfg_data_out = s_q.out_bit;
  assign BUS.cdo_oe_n = s_q.cdo_oe_n;
  assign BUS.conversion_lane0 = s_q.out_bit;
  assign BUS.lane0_oe_n = s_q.lane0_oe_n;

endmodule

/* File: design/cfg_spi_host.sv */
`timescale 1ns/1ps
module cfg_spi_host
  import cfg_spi_pkg::*;
(
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic CE_I,
  input wire logic [3:0] ADDR_I,
  input wire logic [15:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [15:0] RDATA_O,
  cfg_spi_if.host BUS
);

  typedef enum logic [2:0] {
    H_IDLE = 3'b000,
    H_LOW = 3'b001,
    H_HIGH = 3'b010,
    H_TRAIL = 3'b011,
    H_GAP = 3'b100
  } host_phase_t;

  typedef struct packed {
    host_phase_t phase;
    logic [7:0] half;
    logic [5:0] bitn;
    logic [5:0] last;
    logic [31:0] tx;
    logic [15:0] rx;
    logic rd;
    logic four;
    logic lane0;
    logic crc;
    logic [14:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic crc_err;
    logic [15:0] rdata_o;
    logic sclk;
    logic sel_n;
    logic mosi;
    logic mosi_oe_n;
    logic miso_s1;
    logic miso_s2;
  } host_state_t;

  host_state_t s_q, s_d;
  logic half_done;

  assign half_done = (s_q.half == 8'(SCLK_HALF_CYC - 1));

  // Next state: command port, divider and frame sequencer
  always_comb begin
    s_d = s_q;
    // Read-back line picked by configured mode, then synchronised
    s_d.miso_s1 = !s_q.four ? BUS.cfg_data_bidir :
                  (s_q.lane0 ? BUS.conversion_lane0 : BUS.cfg_data_out);
    s_d.miso_s2 = s_q.miso_s1;
    s_d.half = (s_q.phase == H_IDLE || half_done) ? 8'h00 : s_q.half + 8'h01;
    if (WR_I && s_q.phase == H_IDLE) begin
      case (ADDR_I)
        HOST_ADDR: s_d.addr = WDATA_I[14:0];
        HOST_WDATA: s_d.wdata = WDATA_I[7:0];
        HOST_CTRL: begin
          s_d.rd = WDATA_I[HC_READ];
          s_d.four = WDATA_I[HC_FOUR_WIRE];
          s_d.lane0 = WDATA_I[HC_LANE0];
          s_d.crc = WDATA_I[HC_CRC];
          if (WDATA_I[HC_START]) begin
            // Instruction then data, MSB first; direction bit leads
            s_d.tx = {WDATA_I[HC_READ], s_q.addr, WDATA_I[HC_READ] ? 8'h00 : s_q.wdata,
                      WDATA_I[HC_CRC] ? crc8_byte(CRC_INIT, s_q.wdata) : 8'h00};
            s_d.last = WDATA_I[HC_CRC] ? 6'(FRAME_BITS_CRC - 1) : 6'(FRAME_BITS_PLAIN - 1);
            s_d.bitn = 6'h00;
            s_d.sel_n = 1'b0;
            s_d.mosi = WDATA_I[HC_READ];
            s_d.mosi_oe_n = 1'b0;
            s_d.phase = H_LOW;
          end
        end
        default: begin
        end
      endcase
    end
    // 3-wire read: let go of the shared line two cycles into the last instruction high half;
    // the device's first stage has taken the bit, and it drives only a cycle later
    if (s_q.phase == H_HIGH && s_q.half == 8'h01 && s_q.rd && !s_q.four &&
        s_q.bitn == 6'(INSTR_BITS - 1)) begin
      s_d.mosi_oe_n = 1'b1;
    end
    if (half_done) begin
      case (s_q.phase)
        H_LOW: begin
          s_d.sclk = 1'b1;
          s_d.phase = H_HIGH;
        end
        H_HIGH: begin
          // Sample late in the high half, just ahead of the device's falling-edge change
          s_d.rx = {s_q.rx[14:0], s_q.miso_s2};
          s_d.sclk = 1'b0;
          s_d.bitn = s_q.bitn + 6'h01;
          if (s_q.bitn == s_q.last) begin
            s_d.phase = H_TRAIL;
          end else begin
            s_d.tx = {s_q.tx[30:0], 1'b0};
            s_d.mosi = s_q.tx[30];
            s_d.phase = H_LOW;
          end
        end
        H_TRAIL: begin
          s_d.sel_n = 1'b1;
          s_d.mosi_oe_n = 1'b1;
          s_d.rdata = s_q.crc ? s_q.rx[15:8] : s_q.rx[7:0];
          s_d.crc_err = s_q.crc && s_q.rd && (crc8_byte(CRC_INIT, s_q.rx[15:8]) != s_q.rx[7:0]);
          s_d.phase = H_GAP;
        end
        H_GAP: s_d.phase = H_IDLE;
        default: s_d.phase = H_IDLE;
      endcase
    end
    // Read data stand in the cycle after the strobe only
    s_d.rdata_o = 16'h0000;
    if (RD_I) begin
      case (ADDR_I)
        HOST_CTRL: s_d.rdata_o = {11'h000, s_q.crc, s_q.lane0, s_q.four, s_q.rd, 1'b0};
        HOST_ADDR: s_d.rdata_o = {1'b0, s_q.addr};
        HOST_WDATA: s_d.rdata_o = {8'h00, s_q.wdata};
        HOST_STATUS: s_d.rdata_o = {14'h0000, s_q.crc_err, s_q.phase != H_IDLE};
        HOST_RDATA: s_d.rdata_o = {8'h00, s_q.rdata};
        default: s_d.rdata_o = 16'h0000;
      endcase
    end
  end

  // State register; clock enable freezes everything
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      s_q <= '0;
      s_q.sel_n <= 1'b1;
      s_q.mosi_oe_n <= 1'b1;
    end else if (CE_I) begin
      s_q <= s_d;
    end
  end

  assign RDATA_O = s_q.rdata_o;
  assign BUS.cfg_serial_clock = s_q.sclk;
  assign BUS.frame_sel_n = s_q.sel_n;
  assign BUS.host_sdio_o = s_q.mosi;
  assign BUS.host_sdio_oe_n = s_q.mosi_oe_n;

endmodule

/* File: shared/cfg_spi_if.sv */
`timescale 1ns/1ps
interface cfg_spi_if;
  logic cfg_serial_clock;
  logic frame_sel_n;
  logic host_sdio_o;
  logic host_sdio_oe_n;
  logic dev_sdio_o;
  logic dev_sdio_oe_n;
  logic cfg_data_out;
  logic cdo_oe_n;
  logic conversion_lane0;
  logic lane0_oe_n;
  logic cfg_data_bidir;

  // Shared line resolved from enables; idles high like a pulled-up pin
  assign cfg_data_bidir = !host_sdio_oe_n ? host_sdio_o :
                          (!dev_sdio_oe_n ? dev_sdio_o : 1'b1);

  modport dev (
    input cfg_serial_clock, frame_sel_n, cfg_data_bidir,
    output dev_sdio_o, dev_sdio_oe_n, cfg_data_out, cdo_oe_n, conversion_lane0, lane0_oe_n
  );
  modport host (
    output cfg_serial_clock, frame_sel_n, host_sdio_o, host_sdio_oe_n,
    input cfg_data_bidir, cfg_data_out, cdo_oe_n, conversion_lane0, lane0_oe_n
  );
endinterface

/* File: shared/cfg_spi_pkg.sv */
package cfg_spi_pkg;

  // Timing of the configuration link
  localparam int CLK_PERIOD_NS = 20;
  localparam int SCLK_PERIOD_NS = 160;
  // Host divider: half a serial clock period in system clocks
  localparam int SCLK_HALF_CYC = SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);

  // Frame layout
  localparam int INSTR_BITS = 16;
  localparam int BYTE_BITS = 8;
  localparam int ADDR_BITS = 15;
  localparam int FRAME_BITS_PLAIN = INSTR_BITS + BYTE_BITS;
  localparam int FRAME_BITS_CRC = INSTR_BITS + 2 * BYTE_BITS;

  // Device register space
  localparam int MEM_TOP = 113;
  localparam logic [14:0] ADDR_LAST = 15'h0071;
  localparam logic [14:0] ADDR_PORT_CFG_A = 15'h0000;
  localparam logic [14:0] ADDR_PORT_CFG_B = 15'h0001;
  localparam logic [14:0] ADDR_LOOP_CFG_A = 15'h000e;
  localparam logic [14:0] ADDR_LOOP_CFG_B = 15'h000f;
  localparam logic [14:0] ADDR_PORT_CFG_C = 15'h0010;
  localparam logic [14:0] ADDR_PORT_CFG_D = 15'h0014;
  localparam logic [7:0] REG_RESET = 8'h00;

  // Field positions
  localparam int BIT_FOUR_WIRE = 4;
  localparam int BIT_ADDR_DIR = 5;
  localparam int BIT_INSTR_MODE = 7;
  localparam int BIT_LANE0 = 0;
  localparam int BIT_KEEP_LOOP = 2;
  localparam int BIT_CRC_EN = 0;

  // Bus checksum
  localparam logic [7:0] CRC_INIT = 8'ha5;
  localparam logic [7:0] CRC_POLY = 8'h07;

  // Host command registers
  localparam logic [3:0] HOST_CTRL = 4'h0;
  localparam logic [3:0] HOST_ADDR = 4'h1;
  localparam logic [3:0] HOST_WDATA = 4'h2;
  localparam logic [3:0] HOST_STATUS = 4'h3;
  localparam logic [3:0] HOST_RDATA = 4'h4;
  localparam int HC_START = 0;
  localparam int HC_READ = 1;
  localparam int HC_FOUR_WIRE = 2;
  localparam int HC_LANE0 = 3;
  localparam int HC_CRC = 4;
  localparam int HS_BUSY = 0;
  localparam int HS_CRC_ERR = 1;

  typedef logic [MEM_TOP:0][7:0] reg_file_t;

  // Checksum x^8+x^2+x+1 over one byte, MSB first
  function automatic logic [7:0] crc8_byte(input logic [7:0] init, input logic [7:0] data);
    logic [7:0] c;
    logic fb;
    c = init;
    for (int i = 7; i >= 0; i--) begin
      fb = c[7] ^ data[i];
      c = {c[6:0], 1'b0} ^ (fb ? CRC_POLY : 8'h00);
    end
    return c;
  endfunction

endpackage

/* File: testbench/cfg_spi_properties.sv */
`timescale 1ns/1ps
module cfg_spi_properties (
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic cfg_serial_clock,
  input wire logic frame_sel_n,
  input wire logic host_sdio_o,
  input wire logic host_sdio_oe_n,
  input wire logic dev_sdio_o,
  input wire logic dev_sdio_oe_n,
  input wire logic cdo_oe_n,
  input wire logic lane0_oe_n
);
  logic [5:0] rise_cnt_q;
  logic dev_idle;

  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!RST_N_I);

  // No readout path of the device is driving
  assign dev_idle = dev_sdio_oe_n && cdo_oe_n && lane0_oe_n;

  // Serial clock rises within the current frame
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      rise_cnt_q <= 6'h00;
    end else if (frame_sel_n) begin
      rise_cnt_q <= 6'h00;
    end else if ($rose(cfg_serial_clock)) begin
      rise_cnt_q <= rise_cnt_q + 6'h01;
    end
  end

  a_sclk_idle_low: assert property (frame_sel_n |-> !cfg_serial_clock)
    else $error("serial clock high outside a frame");
  a_frame_bit_count: assert property ($rose(frame_sel_n) |->
    (rise_cnt_q == 6'h18 || rise_cnt_q == 6'h20))
    else $error("frame length not a whole instruction and data");
  a_sclk_high_len: assert property ($rose(cfg_serial_clock) |->
    cfg_serial_clock[*4] ##1 !cfg_serial_clock)
    else $error("serial clock high half has wrong length");
  a_host_data_hold: assert property ((!host_sdio_oe_n && cfg_serial_clock &&
    $past(cfg_serial_clock)) |-> $stable(host_sdio_o))
    else $error("host data moved while serial clock high");
  a_dev_data_hold: assert property ((!dev_idle && cfg_serial_clock &&
    $past(cfg_serial_clock)) |-> $stable(dev_sdio_o))
    else $error("device data moved while serial clock high");
  a_no_contention: assert property (!(!host_sdio_oe_n && !dev_sdio_oe_n))
    else $error("both ends drive the shared line");
  a_one_readout: assert property ($onehot0({!dev_sdio_oe_n, !cdo_oe_n, !lane0_oe_n}))
    else $error("more than one readout path driven");
  a_turn_after_instr: assert property ($fell(dev_idle) |-> rise_cnt_q == 6'h10)
    else $error("device drove before instruction ended");
  a_release_idle: assert property (frame_sel_n[*6] |-> dev_idle)
    else $error("device still driving after frame end");

  cover property ($fell(dev_sdio_oe_n));
  cover property ($fell(cdo_oe_n));
  cover property ($fell(lane0_oe_n));
endmodule

/* File: testbench/register_config_serial_bus_bench.sv */
`timescale 1ns/1ps
`define CHECK(nm, got, exp) begin \
  cmp_count++; \
  if ((got) !== (exp)) begin \
    failures++; \
    $display("ERROR %s expected %h seen %h", nm, exp, got); \
  end \
end

module register_config_serial_bus_bench;
  import cfg_spi_pkg::*;
  logic clk, rst_n, wr, rd, four_wire, tail_bit;
  logic [3:0] addr;
  logic [15:0] wdata, rdata, st, v;
  logic [2:0] bits[$];
  int failures = 0;
  int cmp_count = 0;
  int n_dev, n_cdo, n_lane;

  cfg_spi_if bus_if();
  cfg_spi_host cfg_spi_host_inst (.CLK_I(clk), .RST_N_I(rst_n), .CE_I(1'b1), .ADDR_I(addr),
    .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .BUS(bus_if.host));
  cfg_spi_device cfg_spi_device_inst (.CLK_I(clk), .RST_N_I(rst_n), .CE_I(1'b1),
    .FOUR_WIRE_O(four_wire), .BUS(bus_if.dev));
  cfg_spi_properties cfg_spi_properties_inst (.CLK_I(clk), .RST_N_I(rst_n),
    .cfg_serial_clock(bus_if.cfg_serial_clock), .frame_sel_n(bus_if.frame_sel_n),
    .host_sdio_o(bus_if.host_sdio_o), .host_sdio_oe_n(bus_if.host_sdio_oe_n),
    .dev_sdio_o(bus_if.dev_sdio_o), .dev_sdio_oe_n(bus_if.dev_sdio_oe_n),
    .cdo_oe_n(bus_if.cdo_oe_n), .lane0_oe_n(bus_if.lane0_oe_n));

  // 50 MHz system clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Sample early in the high half, before the host lets go of the shared line
  always @(posedge bus_if.cfg_serial_clock) begin
    #10;
    if (!bus_if.frame_sel_n) begin
      bits.push_back({bus_if.cfg_data_bidir, bus_if.cfg_data_out, bus_if.conversion_lane0});
    end
  end

  // Line level as select rises: the byte a stream sends next, or the pull-up once released
  always @(posedge bus_if.frame_sel_n) tail_bit = bus_if.cfg_data_bidir;

  // Cycles in which each readout path is driven
  always @(posedge clk) begin
    if (!bus_if.dev_sdio_oe_n) n_dev++;
    if (!bus_if.cdo_oe_n) n_cdo++;
    if (!bus_if.lane0_oe_n) n_lane++;
  end

  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [3:0] a, output logic [15:0] q);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    q = rdata;
  endtask

  // Own checksum model, kept apart from the design's helper
  function automatic logic [7:0] crc_ref(input logic [7:0] d);
    logic [7:0] c;
    c = 8'ha5;
    for (int i = 7; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
    return c;
  endfunction

  // One host frame, then the wire, the drive paths and the result are judged
  task automatic run_frame(input logic rw, input logic [14:0] a, input logic [7:0] d,
      input logic fw, input logic ln0, input logic crc);
    logic [15:0] ins;
    logic [7:0] dat, cb;
    int ln, nb;
    ln = (rw && fw) ? (ln0 ? 0 : 1) : 2;
    nb = crc ? 32 : 24;
    bits.delete();
    n_dev = 0;
    n_cdo = 0;
    n_lane = 0;
    wr_reg(HOST_ADDR, {1'b0, a});
    wr_reg(HOST_WDATA, {8'h00, d});
    wr_reg(HOST_CTRL, {11'h000, crc, ln0, fw, rw, 1'b1});
    st = 16'h0001;
    for (int k = 0; k < 500 && st[HS_BUSY] !== 1'b0; k++) rd_reg(HOST_STATUS, st);
    `CHECK("busy", st[HS_BUSY], 1'b0)
    `CHECK("bit_count", bits.size(), nb)
    if (bits.size() == nb) begin
      for (int k = 0; k < 16; k++) ins[15-k] = bits[k][2];
      for (int k = 0; k < 8; k++) dat[7-k] = bits[16+k][ln];
      `CHECK("instr", ins, {rw, a})
      `CHECK("data", dat, d)
      if (crc) begin
        for (int k = 0; k < 8; k++) cb[7-k] = bits[24+k][ln];
        `CHECK("crc_byte", cb, crc_ref(d))
      end
    end
    `CHECK("dev_drive", n_dev != 0, rw && !fw)
    `CHECK("cdo_drive", n_cdo != 0, rw && fw && !ln0)
    `CHECK("lane_drive", n_lane != 0, rw && fw && ln0)
    if (rw) begin
      rd_reg(HOST_RDATA, v);
      `CHECK("rdata", v[7:0], d)
      if (crc) `CHECK("crc_err", st[HS_CRC_ERR], 1'b0)
    end
  endtask

  task automatic t_reset();
    `CHECK("four_wire", four_wire, 1'b0)
    `CHECK("select", bus_if.frame_sel_n, 1'b1)
    `CHECK("oe", {bus_if.dev_sdio_oe_n, bus_if.cdo_oe_n, bus_if.lane0_oe_n}, 3'h7)
  endtask

  // An inner and the top address, plus one beyond the register space
  task automatic t_three_wire();
    logic [14:0] at[2] = '{15'h000a, 15'h0071};
    logic [7:0] dt[2] = '{8'hc3, 8'ha5};
    for (int i = 0; i < 2; i++) begin
      run_frame(1'b0, at[i], dt[i], 1'b0, 1'b0, 1'b0);
      run_frame(1'b1, at[i], dt[i], 1'b0, 1'b0, 1'b0);
      `CHECK("stream_next", tail_bit, 1'b0)
    end
    run_frame(1'b0, 15'h0072, 8'hff, 1'b0, 1'b0, 1'b0);
    run_frame(1'b1, 15'h0072, 8'h00, 1'b0, 1'b0, 1'b0);
    // Descending stream from the bottom wraps to the top register
    run_frame(1'b1, ADDR_PORT_CFG_A, 8'h00, 1'b0, 1'b0, 1'b0);
    `CHECK("wrap_down", tail_bit, 1'b1)
    // Single-byte mode lets go of the line after the byte
    run_frame(1'b0, ADDR_PORT_CFG_B, 8'h80, 1'b0, 1'b0, 1'b0);
    run_frame(1'b1, 15'h000a, 8'hc3, 1'b0, 1'b0, 1'b0);
    `CHECK("single_byte", tail_bit, 1'b1)
    run_frame(1'b0, ADDR_PORT_CFG_B, 8'h00, 1'b0, 1'b0, 1'b0);
  endtask

  task automatic t_loop();
    run_frame(1'b0, ADDR_LOOP_CFG_A, 8'h05, 1'b0, 1'b0, 1'b0);
    run_frame(1'b1, ADDR_LOOP_CFG_A, 8'h00, 1'b0, 1'b0, 1'b0);
    run_frame(1'b0, ADDR_LOOP_CFG_B, 8'h04, 1'b0, 1'b0, 1'b0);
    run_frame(1'b0, ADDR_LOOP_CFG_A, 8'h05, 1'b0, 1'b0, 1'b0);
    run_frame(1'b1, ADDR_LOOP_CFG_A, 8'h05, 1'b0, 1'b0, 1'b0);
  endtask

  task automatic t_four_wire();
    run_frame(1'b0, ADDR_PORT_CFG_A, 8'h10, 1'b0, 1'b0, 1'b0);
    `CHECK("four_wire", four_wire, 1'b1)
    run_frame(1'b1, 15'h000a, 8'hc3, 1'b1, 1'b0, 1'b0);
    run_frame(1'b0, ADDR_PORT_CFG_D, 8'h01, 1'b0, 1'b0, 1'b0);
    run_frame(1'b1, 15'h000a, 8'hc3, 1'b1, 1'b1, 1'b0);
  endtask

  // A frame that ends before its checksum byte must not commit
  task automatic t_crc();
    run_frame(1'b0, ADDR_PORT_CFG_C, 8'h01, 1'b0, 1'b0, 1'b0);
    run_frame(1'b0, 15'h0020, 8'h77, 1'b0, 1'b0, 1'b0);
    run_frame(1'b1, 15'h0020, 8'h00, 1'b1, 1'b1, 1'b1);
    run_frame(1'b0, 15'h0020, 8'h77, 1'b0, 1'b0, 1'b1);
    run_frame(1'b1, 15'h0020, 8'h77, 1'b1, 1'b1, 1'b1);
  endtask

  task automatic wrap_up();
    if (failures == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    rst_n = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 4'h0;
    wdata = 16'h0000;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset();
    t_three_wire();
    t_loop();
    t_four_wire();
    t_crc();
    wrap_up();
  end

  // Hang guard, well above the twenty-odd frames of the run
  initial begin
    #400000;
    failures++;
    wrap_up();
  end
endmodule
